// ### design/mbs_slave.sv
module mbs_slave
    import mbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] own_addr,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_end,
    output logic [7:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic rd_req,
    output logic [15:0] rd_addr,
    input wire logic [15:0] rd_data,
    output logic wr_en,
    output logic [15:0] wr_addr,
    output logic [15:0] wr_data,
    output logic frame_err
);
    mbs_state_t state_r;
    logic [7:0] buf_r [8];
    logic [3:0] cnt_r;
    logic ovf_r;
    logic [2:0] idx_r;
    logic [15:0] base_r;
    logic [6:0] qty_r;
    logic [6:0] n_r;
    logic [15:0] word_r;
    logic [7:0] tx_data_r;
    logic tx_valid_r;
    logic rd_req_r;
    logic [15:0] rd_addr_r;
    logic wr_en_r;
    logic [15:0] wr_addr_r;
    logic [15:0] wr_data_r;
    logic frame_err_r;
    logic [15:0] rx_crc;
    logic [15:0] tx_crc;
    logic [7:0] tx_pick;

    wire rx_take = (state_r == S_IDLE) && rx_valid;
    wire accept = tx_valid_r && tx_ready;
    wire in_crc = (state_r == S_CRCL) || (state_r == S_CRCH);
    wire send_st = (state_r == S_ECHO) || (state_r == S_RHDR) || (state_r == S_RHI)
        || (state_r == S_RLO) || in_crc;
    wire [7:0] a_byte = buf_r[POS_ADDR];
    wire [7:0] fc = buf_r[POS_FUNC];
    wire [15:0] f1 = {buf_r[POS_F1H], buf_r[POS_F1L]};
    wire [15:0] f2 = {buf_r[POS_F2H], buf_r[POS_F2L]};
    wire crc_ok = (rx_crc == CRC_GOOD);
    wire good = (cnt_r == FRAME_LEN) && !ovf_r && crc_ok;
    wire bcast = (a_byte == ADDR_BCAST);
    wire to_me = (a_byte == own_addr) && !bcast;
    wire do_read = good && to_me && (fc == FC_READ)
        && (f2 >= QTY_MIN) && (f2 <= QTY_MAX);
    wire do_write = good && (to_me || bcast) && (fc == FC_WRITE);
    wire do_diag = good && to_me && (fc == FC_DIAG) && (f1 == SUB_ECHO);

    mbs_crc16 u_rx_crc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clr(state_r == S_EVAL),
        .en(rx_take),
        .data(rx_data),
        .crc(rx_crc)
    );

    mbs_crc16 u_tx_crc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .clr(state_r == S_EVAL),
        .en(accept && !in_crc),
        .data(tx_data_r),
        .crc(tx_crc)
    );

    // receive buffer; bytes past the fixed frame length only mark overflow
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_r <= 4'h0;
            ovf_r <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                buf_r[i] <= 8'h00;
            end
        end else if (state_r == S_EVAL) begin
            cnt_r <= 4'h0;
            ovf_r <= 1'b0;
        end else if (rx_take) begin
            if (cnt_r < FRAME_LEN) begin
                buf_r[cnt_r[2:0]] <= rx_data;
                cnt_r <= cnt_r + 4'h1;
            end else begin
                ovf_r <= 1'b1;
            end
        end
    end

    always_comb begin
        tx_pick = 8'h00;
        unique case (state_r)
            S_ECHO: tx_pick = buf_r[idx_r];
            S_RHDR: begin
                if (idx_r == POS_ADDR) begin
                    tx_pick = buf_r[POS_ADDR];
                end else if (idx_r == POS_FUNC) begin
                    tx_pick = FC_READ;
                end else begin
                    tx_pick = {qty_r, 1'b0};
                end
            end
            S_RHI: tx_pick = word_r[15:8];
            S_RLO: tx_pick = word_r[7:0];
            S_CRCL: tx_pick = tx_crc[7:0];
            S_CRCH: tx_pick = tx_crc[15:8];
            default: tx_pick = 8'h00;
        endcase
    end

    // byte output held until the link takes it
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_valid_r <= 1'b0;
            tx_data_r <= 8'h00;
        end else if (accept) begin
            tx_valid_r <= 1'b0;
        end else if (send_st && !tx_valid_r) begin
            tx_valid_r <= 1'b1;
            tx_data_r <= tx_pick;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_r <= S_IDLE;
            idx_r <= 3'h0;
            base_r <= 16'h0000;
            qty_r <= 7'h00;
            n_r <= 7'h00;
            word_r <= 16'h0000;
            rd_req_r <= 1'b0;
            rd_addr_r <= 16'h0000;
            wr_en_r <= 1'b0;
            wr_addr_r <= 16'h0000;
            wr_data_r <= 16'h0000;
            frame_err_r <= 1'b0;
        end else begin
            wr_en_r <= 1'b0;
            rd_req_r <= 1'b0;
            frame_err_r <= 1'b0;
            unique case (state_r)
                S_IDLE: begin
                    if (rx_end) begin
                        state_r <= S_EVAL;
                    end
                end
                S_EVAL: begin
                    idx_r <= 3'h0;
                    frame_err_r <= !good && (cnt_r != 4'h0);
                    state_r <= S_IDLE;
                    if (do_read) begin
                        base_r <= f1;
                        qty_r <= f2[6:0];
                        state_r <= S_RHDR;
                    end else if (do_write) begin
                        wr_en_r <= 1'b1;
                        wr_addr_r <= f1;
                        wr_data_r <= f2;
                        if (to_me) begin
                            state_r <= S_ECHO;
                        end
                    end else if (do_diag) begin
                        state_r <= S_ECHO;
                    end
                end
                S_ECHO: begin
                    if (accept) begin
                        idx_r <= idx_r + 3'h1;
                        if (idx_r == POS_LAST) begin
                            state_r <= S_IDLE;
                        end
                    end
                end
                S_RHDR: begin
                    if (accept) begin
                        idx_r <= idx_r + 3'h1;
                        if (idx_r == HDR_LAST) begin
                            n_r <= 7'h00;
                            state_r <= S_RFETCH;
                        end
                    end
                end
                S_RFETCH: begin
                    rd_req_r <= 1'b1;
                    rd_addr_r <= base_r + {9'h000, n_r};
                    state_r <= S_RCAP;
                end
                S_RCAP: state_r <= S_RGET;
                S_RGET: begin
                    word_r <= rd_data;
                    state_r <= S_RHI;
                end
                S_RHI: begin
                    if (accept) begin
                        state_r <= S_RLO;
                    end
                end
                S_RLO: begin
                    if (accept) begin
                        n_r <= n_r + 7'h01;
                        state_r <= ((n_r + 7'h01) == qty_r) ? S_CRCL : S_RFETCH;
                    end
                end
                S_CRCL: begin
                    if (accept) begin
                        state_r <= S_CRCH;
                    end
                end
                S_CRCH: begin
                    if (accept) begin
                        state_r <= S_IDLE;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    assign tx_data = tx_data_r;
    assign tx_valid = tx_valid_r;
    assign rd_req = rd_req_r;
    assign rd_addr = rd_addr_r;
    assign wr_en = wr_en_r;
    assign wr_addr = wr_addr_r;
    assign wr_data = wr_data_r;
    assign frame_err = frame_err_r;

    chk_zero_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_EVAL) && bcast && (fc != FC_WRITE) |=> (state_r == S_IDLE) && !wr_en_r)
        else $error("zero address read or diagnostics acted on");
    chk_bcast_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_EVAL) && do_write && bcast |=> wr_en_r && (state_r == S_IDLE)
        ##1 !tx_valid_r [*3])
        else $error("broadcast write not done or answered");
    chk_qty_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_RHDR) |-> (qty_r >= QTY_MIN[6:0]) && (qty_r <= QTY_MAX[6:0]))
        else $error("read quantity out of bound");
    chk_byte_count: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_valid_r && (state_r == S_RHDR) && (idx_r == HDR_LAST)
        |-> (tx_data_r == {qty_r, 1'b0}) && (tx_data_r >= BCNT_MIN) && (tx_data_r <= BCNT_MAX))
        else $error("byte count wrong");
    chk_echo_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_valid_r && (state_r == S_ECHO) |-> (tx_data_r == buf_r[idx_r]))
        else $error("echo byte differs from query");
    chk_word_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_RHI) && accept |-> (tx_data_r == word_r[15:8]) ##1 (state_r == S_RLO))
        else $error("register word not high byte first");
    chk_rd_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_req_r |-> (rd_addr_r == base_r + {9'h000, n_r}) ##2 (state_r == S_RHI))
        else $error("read address not ascending from start");
    chk_crc_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_CRCL) && accept |-> (tx_data_r == tx_crc[7:0])
        ##1 (state_r == S_CRCH) && $stable(tx_crc))
        else $error("crc byte order wrong");
    chk_bad_crc: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_EVAL) && !crc_ok && (cnt_r != 4'h0)
        |=> (state_r == S_IDLE) && !wr_en_r && frame_err_r)
        else $error("frame with bad crc acted on");
    chk_foreign: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_EVAL) && !bcast && (a_byte != own_addr)
        |=> (state_r == S_IDLE) && !wr_en_r)
        else $error("foreign frame acted on");
    chk_tx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_data_r))
        else $error("tx byte dropped before taken");
endmodule

// ### design/mbs_pkg.sv
package mbs_pkg;
    localparam logic [7:0] FC_READ = 8'h03;
    localparam logic [7:0] FC_WRITE = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] ADDR_BCAST = 8'h00;
    localparam logic [15:0] SUB_ECHO = 16'h0000;
    localparam logic [15:0] QTY_MIN = 16'h0001;
    localparam logic [15:0] QTY_MAX = 16'h007d;
    localparam logic [7:0] BCNT_MIN = 8'h02;
    localparam logic [7:0] BCNT_MAX = 8'hfa;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'ha001;
    localparam logic [15:0] CRC_GOOD = 16'h0000;
    // register number of offset zero; offsets are passed on unchanged
    localparam int HOLD_BASE = 40001;
    localparam logic [3:0] FRAME_LEN = 4'h8;
    localparam logic [2:0] POS_ADDR = 3'h0;
    localparam logic [2:0] POS_FUNC = 3'h1;
    localparam logic [2:0] POS_F1H = 3'h2;
    localparam logic [2:0] POS_F1L = 3'h3;
    localparam logic [2:0] POS_F2H = 3'h4;
    localparam logic [2:0] POS_F2L = 3'h5;
    localparam logic [2:0] POS_LAST = 3'h7;
    localparam logic [2:0] HDR_LAST = 3'h2;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_EVAL = 4'h1,
        S_ECHO = 4'h2,
        S_RHDR = 4'h3,
        S_RFETCH = 4'h4,
        S_RCAP = 4'h5,
        S_RGET = 4'h6,
        S_RHI = 4'h7,
        S_RLO = 4'h8,
        S_CRCL = 4'h9,
        S_CRCH = 4'ha
    } mbs_state_t;
endpackage

// ### design/mbs_crc16.sv
module mbs_crc16
    import mbs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic en,
    input wire logic [7:0] data,
    output logic [15:0] crc
);
    logic [15:0] crc_nxt;

    always_comb begin
        crc_nxt = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            crc_nxt = crc_nxt[0] ? ((crc_nxt >> 1) ^ CRC_POLY) : (crc_nxt >> 1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n || clr) begin
            crc <= CRC_INIT;
        end else if (en) begin
            crc <= crc_nxt;
        end
    end
endmodule

// ### verification/mbs_master_model.sv
module mbs_master_model (
    input wire logic clk_sys,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic rx_end,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] reply_q[$];
    bit slow = 1'b0;
    bit [1:0] cnt = 2'h0;

    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        rx_end = 1'b0;
        tx_ready = 1'b0;
    end

    // stalls two cycles of four when slow
    always @(negedge clk_sys) begin
        cnt <= cnt + 2'h1;
        tx_ready <= slow ? cnt[1] : 1'b1;
    end

    always @(posedge clk_sys) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            reply_q.push_back(tx_data);
        end
    end

    // bytes go out in frame order, line shows garbage between bytes
    task automatic send(input logic [7:0] f[$]);
        foreach (f[i]) begin
            @(negedge clk_sys);
            rx_data = f[i];
            rx_valid = 1'b1;
            @(negedge clk_sys);
            rx_valid = 1'b0;
            rx_data = ~f[i];
        end
        @(negedge clk_sys);
        rx_end = 1'b1;
        @(negedge clk_sys);
        rx_end = 1'b0;
    endtask
endmodule

// ### verification/mbs_slave_tb_top.sv
module mbs_slave_tb_top;
    import mbs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef logic [7:0] mbs_bq_t[$];
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] own_addr = 8'h11;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_end, tx_valid, tx_ready, rd_req, wr_en, frame_err;
    logic [15:0] rd_addr, wr_addr, wr_data, last_wa, last_wd;
    logic [15:0] rd_data = 16'h0000;
    logic rd_pend = 1'b0;
    int n_mismatch = 0;
    int n_tests = 0;
    int n_wr = 0;
    int n_err = 0;
    mbs_bq_t none;

    always #20 clk_sys = ~clk_sys;

    mbs_slave u_mbs_slave (.clk_sys(clk_sys), .rst_n(rst_n), .own_addr(own_addr),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
        .frame_err(frame_err));
    mbs_master_model u_mbs_master_model (.clk_sys(clk_sys), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_end(rx_end), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready));

    function automatic logic [15:0] mval(input logic [15:0] a);
        return {a[7:0], a[15:8]} ^ 16'h5ac3;
    endfunction

    // holding store: word stands only across the second edge after rd_req rises
    always @(negedge clk_sys) begin
        rd_pend <= (rd_req === 1'b1);
        rd_data <= rd_pend ? mval(rd_addr) : ~rd_data;
    end

    always @(posedge clk_sys) begin
        if (wr_en === 1'b1) begin
            n_wr <= n_wr + 1;
            last_wa <= wr_addr;
            last_wd <= wr_data;
        end
        if (frame_err === 1'b1) n_err <= n_err + 1;
    end

    function automatic mbs_bq_t seal(input mbs_bq_t q, input bit bad);
        logic [15:0] c;
        c = CRC_INIT;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
        end
        q.push_back(c[7:0] ^ {7'h00, bad});
        q.push_back(c[15:8]);
        return q;
    endfunction

    function automatic mbs_bq_t mk(input logic [7:0] a, fc, input logic [15:0] f1, f2,
                                   input bit bad);
        return seal({a, fc, f1[15:8], f1[7:0], f2[15:8], f2[7:0]}, bad);
    endfunction

    task automatic chk(input logic [15:0] seen, exp, input string msg);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic run(input mbs_bq_t q, e, input int nwr, nerr, input bit keep);
        if (!keep) begin
            n_wr = 0;
            n_err = 0;
        end
        u_mbs_master_model.reply_q.delete();
        u_mbs_master_model.send(q);
        for (int i = 0; i < 4000; i++) begin
            @(negedge clk_sys);
            if (i > 40 && u_mbs_master_model.reply_q.size() >= e.size()) break;
        end
        repeat (10) @(negedge clk_sys);
        chk(16'(u_mbs_master_model.reply_q.size()), 16'(e.size()), "reply length");
        foreach (e[i]) begin
            if (i < u_mbs_master_model.reply_q.size())
                chk({8'h00, u_mbs_master_model.reply_q[i]}, {8'h00, e[i]}, "reply byte");
        end
        chk(16'(n_wr), 16'(nwr), "write count");
        chk(16'(n_err), 16'(nerr), "crc error count");
    endtask

    task automatic t_write;
        mbs_bq_t q;
        q = mk(8'h11, FC_WRITE, 16'h000d, 16'h1770, 1'b0);
        u_mbs_master_model.slow = 1'b1;
        run(q, q, 1, 0, 1'b0);
        chk(last_wa, 16'h000d, "write offset");
        chk(last_wd, 16'h1770, "write value");
        u_mbs_master_model.slow = 1'b0;
        $display("test write done");
    endtask

    task automatic t_bcast;
        mbs_bq_t d;
        n_wr = 0;
        n_err = 0;
        d = mk(8'h11, FC_DIAG, SUB_ECHO, 16'hffff, 1'b0);
        u_mbs_master_model.send(mk(ADDR_BCAST, FC_WRITE, 16'h0001, 16'hbeef, 1'b0));
        repeat (2) @(negedge clk_sys);
        run(d, d, 1, 0, 1'b1);
        chk(last_wa, 16'h0001, "broadcast offset");
        chk(last_wd, 16'hbeef, "broadcast value");
        d = mk(8'h11, FC_DIAG, SUB_ECHO, 16'h0000, 1'b0);
        run(d, d, 0, 0, 1'b0);
        $display("test broadcast and echo done");
    endtask

    task automatic t_read(input logic [15:0] start, qty);
        mbs_bq_t e;
        logic [15:0] v;
        e = {own_addr, FC_READ, 8'(qty * 16'h0002)};
        for (int n = 0; n < int'(qty); n++) begin
            v = mval(start + 16'(n));
            e.push_back(v[15:8]);
            e.push_back(v[7:0]);
        end
        run(mk(own_addr, FC_READ, start, qty, 1'b0), seal(e, 1'b0), 0, 0, 1'b0);
        $display("test read done");
    endtask

    task automatic t_refuse;
        mbs_bq_t q;
        run(mk(8'h11, FC_READ, 16'h0000, QTY_MAX + 16'h0001, 1'b0), none, 0, 0, 1'b0);
        run(mk(8'h11, FC_READ, 16'h0000, 16'h0000, 1'b0), none, 0, 0, 1'b0);
        run(mk(ADDR_BCAST, FC_READ, 16'h0000, 16'h0003, 1'b0), none, 0, 0, 1'b0);
        run(mk(ADDR_BCAST, FC_DIAG, SUB_ECHO, 16'h1234, 1'b0), none, 0, 0, 1'b0);
        run(mk(8'h11, FC_DIAG, 16'h0001, 16'h1234, 1'b0), none, 0, 0, 1'b0);
        run(mk(8'h12, FC_WRITE, 16'h0002, 16'h5555, 1'b0), none, 0, 0, 1'b0);
        run(mk(8'h11, FC_WRITE, 16'h0002, 16'h5555, 1'b1), none, 0, 1, 1'b0);
        // overlong write frame: one byte past the fixed length
        q = mk(8'h11, FC_WRITE, 16'h0002, 16'h5555, 1'b0);
        q.push_back(8'h00);
        run(q, none, 0, 1, 1'b0);
        $display("test refused frames done");
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge clk_sys);
        rst_n = 1'b1;
        t_write();
        t_bcast();
        t_read(16'h03eb, 16'h0003);
        own_addr = 8'h7f;
        t_read(16'hffff, QTY_MIN);
        own_addr = 8'h11;
        u_mbs_master_model.slow = 1'b1;
        t_read(16'h0000, QTY_MAX);
        u_mbs_master_model.slow = 1'b0;
        t_refuse();
        end_of_test();
    end

    initial begin
        #(40 * 60000);
        n_mismatch++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule
